// file: shared/sync_serial_pkg.sv
package sync_serial_pkg;

   // ----------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] CONTROL_REG_OFS = 8'h00;
   localparam logic [7:0] CLOCK_PRESCALE_REG_OFS = 8'h04;
   localparam logic [7:0] RECEIVE_CLOCK_MODE_REG_OFS = 8'h10;
   localparam logic [7:0] TRANSMIT_CLOCK_MODE_REG_OFS = 8'h18;
   localparam logic [7:0] TRANSMIT_FRAME_MODE_REG_OFS = 8'h1C;
   localparam logic [7:0] TRANSMIT_HOLDING_REG_OFS = 8'h24;
   localparam logic [7:0] TRANSMIT_SYNC_REG_OFS = 8'h34;
   localparam logic [7:0] STATUS_REG_OFS = 8'h40;
   localparam logic [7:0] IRQ_ENABLE_REG_OFS = 8'h44;
   localparam logic [7:0] IRQ_DISABLE_REG_OFS = 8'h48;
   localparam logic [7:0] IRQ_MASK_REG_OFS = 8'h4C;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int CR_RXEN = 0;
   localparam int CR_RXDIS = 1;
   localparam int CR_TXEN = 8;
   localparam int CR_TXDIS = 9;
   localparam int DIV_W = 12;
   localparam int CKS_LSB = 0;
   localparam int CKO_LSB = 2;
   localparam int CKI_BIT = 5;
   localparam int START_LSB = 8;
   localparam int DATLEN_LSB = 0;
   localparam int DATDEF_BIT = 5;
   localparam int MSBF_BIT = 7;
   localparam int FSLEN_LSB = 16;
   localparam int FSDEN_BIT = 23;
   localparam int SYNC_W = 16;
   localparam int SR_TRANSMIT_READY_FLAG = 0;
   localparam int SR_TRANSMITTER_EMPTY_FLAG = 1;
   localparam int SR_TXEN = 16;
   localparam int SR_RXEN = 17;
   localparam int IRQ_W = 2;

   // ----------------------------------------
   // field encodings and reset values
   // ----------------------------------------
   localparam logic [1:0] CKS_PIN = 2'h0;
   localparam logic [1:0] CKS_OTHER = 2'h1;
   localparam logic [1:0] CKS_DIV = 2'h2;
   localparam logic [2:0] CKO_NONE = 3'h0;
   localparam logic [2:0] CKO_CONT = 3'h1;
   localparam logic [2:0] CKO_XFER = 3'h2;
   localparam logic [3:0] START_CONT = 4'h0;
   localparam logic [3:0] START_RX = 4'h1;
   localparam logic [3:0] START_FS_FALL = 4'h4;
   localparam logic [3:0] START_FS_RISE = 4'h5;
   localparam logic [31:0] RESET_VALUE = 32'h0000_0000;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic [3:0] start;
      logic clock_invert;
      logic [2:0] clock_output_mode;
      logic [1:0] clock_source_select;
   } clock_mode_t;

   typedef struct packed {
      logic fsden;
      logic [3:0] fslen;
      logic msbf;
      logic datdef;
      logic [4:0] datlen;
   } frame_mode_t;

   typedef enum logic [1:0] {
      TX_IDLE,
      TX_WAIT,
      TX_SYNC,
      TX_DATA
   } tx_state_t;

   typedef struct packed {
      logic [DIV_W-1:0] div;
      clock_mode_t rmode;
      clock_mode_t tmode;
      frame_mode_t fmode;
      logic [31:0] hold;
      logic [SYNC_W-1:0] tsync;
      logic [31:0] shreg;
      logic [4:0] cnt;
      tx_state_t state;
      logic hold_full;
      logic armed;
      logic txen;
      logic rxen;
      logic [IRQ_W-1:0] imask;
      logic fs_q;
      logic tclk_q;
      logic tx_out;
      logic tclk_pin;
      logic tclk_oe;
      logic rclk_pin;
      logic rclk_oe;
      logic rsec_clk;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } core_state_t;

endpackage

// file: design/pin_sync.sv
`timescale 1ns/1ps
// ----------------------------------------
// two-stage synchroniser, one per bit
// ----------------------------------------
module pin_sync import sync_serial_pkg::*; #(
   parameter int WIDTH = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta;

   // first stage feeds only the second stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= '0;
         sync_out <= '0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end

endmodule

// file: design/clock_divider.sv
`timescale 1ns/1ps
// ----------------------------------------
// shared divider: each phase lasts div cycles
// ----------------------------------------
module clock_divider import sync_serial_pkg::*; #(
   parameter int W = DIV_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] div,
   output logic div_clk
);

   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;
   logic next_clk;

   // a zero factor parks the divider low
   always_comb begin
      next_cnt = cnt;
      next_clk = div_clk;
      if (div == '0) begin
         next_cnt = '0;
         next_clk = 1'b0;
      end else if (cnt >= div - W'(1)) begin
         next_cnt = '0;
         next_clk = ~div_clk;
      end else begin
         next_cnt = cnt + W'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= '0;
         div_clk <= 1'b0;
      end else begin
         cnt <= next_cnt;
         div_clk <= next_clk;
      end
   end

endmodule

// file: design/sync_serial_controller.sv
`timescale 1ns/1ps
module sync_serial_controller import sync_serial_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic tx_serial_clock_pin_in,
   output logic tx_serial_clock_pin_out,
   output logic tx_serial_clock_pin_oe,
   input wire logic rx_serial_clock_pin_in,
   output logic rx_serial_clock_pin_out,
   output logic rx_serial_clock_pin_oe,
   input wire logic tx_frame_sync_pin,
   output logic tx_serial_out,
   output logic rx_section_clock
);

   // ----------------------------------------
   // pin synchronisers and divider
   // ----------------------------------------
   logic [2:0] pins_s;
   logic div_clk;
   logic tk_s;
   logic rk_s;
   logic fs_s;

   // external clocks are only used after two flops
   pin_sync #(.WIDTH(3)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({tx_frame_sync_pin, rx_serial_clock_pin_in,
                 tx_serial_clock_pin_in}),
      .sync_out(pins_s)
   );

   assign tk_s = pins_s[0];
   assign rk_s = pins_s[1];
   assign fs_s = pins_s[2];

   // ----------------------------------------
   // state
   // ----------------------------------------
   core_state_t s;
   core_state_t n;

   clock_divider #(.W(DIV_W)) u_div (
      .pclk(pclk),
      .presetn(presetn),
      .div(s.div),
      .div_clk(div_clk)
   );

   // left-align msb-first words so the out bit is always bit 31
   function automatic logic [31:0] align(input logic [31:0] word,
                                         input logic [4:0] len,
                                         input logic msbf);
      logic [31:0] r;
      r = word;
      if (msbf) begin
         r = word << (5'd31 - len);
      end
      return r;
   endfunction

   function automatic logic head(input logic [31:0] sh,
                                 input logic msbf);
      logic b;
      b = msbf ? sh[31] : sh[0];
      return b;
   endfunction

   function automatic logic [31:0] shift(input logic [31:0] sh,
                                         input logic msbf);
      logic [31:0] r;
      r = msbf ? (sh << 1) : (sh >> 1);
      return r;
   endfunction

   logic setup;
   logic wr;
   logic tx_base;
   logic rx_base;
   logic tx_sel;
   logic rx_sel;
   logic tx_int;
   logic tx_fall;
   logic fs_rise;
   logic fs_fall;
   logic start_hit;
   logic busy;
   logic [31:0] status;
   logic [31:0] rdval;
   logic rd_ok;
   logic [31:0] sh_n;
   logic [4:0] sync_len;

   // ----------------------------------------
   // clock selection
   // ----------------------------------------
   // the cross paths use the other side's base clock, so selecting
   // each other's clock cannot build a combinational loop
   always_comb begin
      tx_base = (s.tmode.clock_source_select == CKS_DIV) ? div_clk : tk_s;
      rx_base = (s.rmode.clock_source_select == CKS_DIV) ? div_clk : rk_s;
      case (s.tmode.clock_source_select)
         CKS_PIN: tx_sel = tk_s;
         CKS_OTHER: tx_sel = rx_base;
         CKS_DIV: tx_sel = div_clk;
         default: tx_sel = 1'b0;
      endcase
      case (s.rmode.clock_source_select)
         CKS_PIN: rx_sel = rk_s;
         CKS_OTHER: rx_sel = tx_base;
         CKS_DIV: rx_sel = div_clk;
         default: rx_sel = 1'b0;
      endcase
   end

   // inversion acts only on what the section itself uses
   assign tx_int = tx_sel ^ s.tmode.clock_invert;
   assign tx_fall = s.tclk_q & ~tx_int;
   assign fs_rise = fs_s & ~s.fs_q;
   assign fs_fall = ~fs_s & s.fs_q;
   assign busy = (s.state == TX_SYNC) || (s.state == TX_DATA);
   assign sync_len = {1'b0, s.fmode.fslen};

   // start event decode for the waiting transmitter
   always_comb begin
      case (s.tmode.start)
         START_FS_RISE: start_hit = fs_rise;
         START_FS_FALL: start_hit = fs_fall;
         START_RX: start_hit = s.rxen;
         default: start_hit = 1'b1;
      endcase
   end

   // ----------------------------------------
   // status and read mux
   // ----------------------------------------
   always_comb begin
      status = RESET_VALUE;
      status[SR_TRANSMIT_READY_FLAG] = ~s.hold_full;
      status[SR_TRANSMITTER_EMPTY_FLAG] = ~s.hold_full && (s.state == TX_IDLE);
      status[SR_TXEN] = s.txen;
      status[SR_RXEN] = s.rxen;
   end

   always_comb begin
      rdval = RESET_VALUE;
      rd_ok = 1'b1;
      case (paddr)
         CONTROL_REG_OFS: rdval = RESET_VALUE;
         CLOCK_PRESCALE_REG_OFS: rdval[DIV_W-1:0] = s.div;
         RECEIVE_CLOCK_MODE_REG_OFS: begin
            rdval[CKS_LSB +: 2] = s.rmode.clock_source_select;
            rdval[CKO_LSB +: 3] = s.rmode.clock_output_mode;
            rdval[CKI_BIT] = s.rmode.clock_invert;
            rdval[START_LSB +: 4] = s.rmode.start;
         end
         TRANSMIT_CLOCK_MODE_REG_OFS: begin
            rdval[CKS_LSB +: 2] = s.tmode.clock_source_select;
            rdval[CKO_LSB +: 3] = s.tmode.clock_output_mode;
            rdval[CKI_BIT] = s.tmode.clock_invert;
            rdval[START_LSB +: 4] = s.tmode.start;
         end
         TRANSMIT_FRAME_MODE_REG_OFS: begin
            rdval[DATLEN_LSB +: 5] = s.fmode.datlen;
            rdval[DATDEF_BIT] = s.fmode.datdef;
            rdval[MSBF_BIT] = s.fmode.msbf;
            rdval[FSLEN_LSB +: 4] = s.fmode.fslen;
            rdval[FSDEN_BIT] = s.fmode.fsden;
         end
         TRANSMIT_HOLDING_REG_OFS: rdval = RESET_VALUE;
         TRANSMIT_SYNC_REG_OFS: rdval[SYNC_W-1:0] = s.tsync;
         STATUS_REG_OFS: rdval = status;
         IRQ_ENABLE_REG_OFS: rdval = RESET_VALUE;
         IRQ_DISABLE_REG_OFS: rdval = RESET_VALUE;
         IRQ_MASK_REG_OFS: rdval[IRQ_W-1:0] = s.imask;
         default: rd_ok = 1'b0;
      endcase
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      n = s;
      sh_n = shift(s.shreg, s.fmode.msbf);
      setup = psel && !penable;
      wr = psel && penable && s.pready && pwrite;

      // apb slave: one wait-free access phase after every setup
      n.pready = setup;
      n.pslverr = setup && !rd_ok;
      n.prdata = (setup && !pwrite && rd_ok) ? rdval : RESET_VALUE;

      n.tclk_q = tx_int;
      n.fs_q = fs_s;

      // start edge is latched so a short sync pulse is not missed
      if (s.state == TX_WAIT && start_hit) begin
         n.armed = 1'b1;
      end

      // transmitter, advanced on falling edges of its internal clock
      if (tx_fall) begin
         case (s.state)
            TX_IDLE: begin
               if (s.txen && s.hold_full &&
                   s.tmode.start == START_CONT) begin
                  n.shreg = align(s.hold, s.fmode.datlen, s.fmode.msbf);
                  n.tx_out = head(n.shreg, s.fmode.msbf);
                  n.cnt = s.fmode.datlen;
                  n.hold_full = 1'b0;
                  n.state = TX_DATA;
               end else if (s.txen && s.hold_full) begin
                  n.state = TX_WAIT;
                  n.armed = 1'b0;
               end
            end
            TX_WAIT: begin
               if (s.armed && s.fmode.fsden) begin
                  n.shreg = align({16'h0000, s.tsync}, sync_len,
                                  s.fmode.msbf);
                  n.tx_out = head(n.shreg, s.fmode.msbf);
                  n.cnt = sync_len;
                  n.state = TX_SYNC;
                  n.armed = 1'b0;
               end else if (s.armed) begin
                  n.shreg = align(s.hold, s.fmode.datlen, s.fmode.msbf);
                  n.tx_out = head(n.shreg, s.fmode.msbf);
                  n.cnt = s.fmode.datlen;
                  n.hold_full = 1'b0;
                  n.state = TX_DATA;
                  n.armed = 1'b0;
               end
            end
            TX_SYNC: begin
               if (s.cnt != 5'h00) begin
                  n.shreg = sh_n;
                  n.tx_out = head(sh_n, s.fmode.msbf);
                  n.cnt = s.cnt - 5'h01;
               end else if (s.hold_full) begin
                  n.shreg = align(s.hold, s.fmode.datlen, s.fmode.msbf);
                  n.tx_out = head(n.shreg, s.fmode.msbf);
                  n.cnt = s.fmode.datlen;
                  n.hold_full = 1'b0;
                  n.state = TX_DATA;
               end else begin
                  n.tx_out = s.fmode.datdef;
                  n.state = TX_IDLE;
               end
            end
            TX_DATA: begin
               if (s.cnt != 5'h00) begin
                  n.shreg = sh_n;
                  n.tx_out = head(sh_n, s.fmode.msbf);
                  n.cnt = s.cnt - 5'h01;
               end else if (s.hold_full && s.txen &&
                            s.tmode.start == START_CONT) begin
                  // back-to-back words with no gap in continuous mode
                  n.shreg = align(s.hold, s.fmode.datlen, s.fmode.msbf);
                  n.tx_out = head(n.shreg, s.fmode.msbf);
                  n.cnt = s.fmode.datlen;
                  n.hold_full = 1'b0;
               end else begin
                  n.tx_out = s.fmode.datdef;
                  n.state = TX_IDLE;
               end
            end
            default: n.state = TX_IDLE;
         endcase
      end else if (s.state == TX_IDLE) begin
         n.tx_out = s.fmode.datdef;
      end

      // register writes; a holding write after a load keeps the new word
      if (wr) begin
         case (paddr)
            CONTROL_REG_OFS: begin
               // disable wins over enable when both are written
               if (pwdata[CR_TXEN]) n.txen = 1'b1;
               if (pwdata[CR_TXDIS]) begin
                  n.txen = 1'b0;
                  n.state = TX_IDLE;
               end
               if (pwdata[CR_RXEN]) n.rxen = 1'b1;
               if (pwdata[CR_RXDIS]) n.rxen = 1'b0;
            end
            CLOCK_PRESCALE_REG_OFS: n.div = pwdata[DIV_W-1:0];
            RECEIVE_CLOCK_MODE_REG_OFS: begin
               n.rmode.clock_source_select = pwdata[CKS_LSB +: 2];
               n.rmode.clock_output_mode = pwdata[CKO_LSB +: 3];
               n.rmode.clock_invert = pwdata[CKI_BIT];
               n.rmode.start = pwdata[START_LSB +: 4];
            end
            TRANSMIT_CLOCK_MODE_REG_OFS: begin
               n.tmode.clock_source_select = pwdata[CKS_LSB +: 2];
               n.tmode.clock_output_mode = pwdata[CKO_LSB +: 3];
               n.tmode.clock_invert = pwdata[CKI_BIT];
               n.tmode.start = pwdata[START_LSB +: 4];
            end
            TRANSMIT_FRAME_MODE_REG_OFS: begin
               n.fmode.datlen = pwdata[DATLEN_LSB +: 5];
               n.fmode.datdef = pwdata[DATDEF_BIT];
               n.fmode.msbf = pwdata[MSBF_BIT];
               n.fmode.fslen = pwdata[FSLEN_LSB +: 4];
               n.fmode.fsden = pwdata[FSDEN_BIT];
            end
            TRANSMIT_HOLDING_REG_OFS: begin
               n.hold = pwdata;
               n.hold_full = 1'b1;
            end
            TRANSMIT_SYNC_REG_OFS: n.tsync = pwdata[SYNC_W-1:0];
            IRQ_ENABLE_REG_OFS: n.imask = s.imask | pwdata[IRQ_W-1:0];
            IRQ_DISABLE_REG_OFS: n.imask = s.imask & ~pwdata[IRQ_W-1:0];
            default: n.imask = s.imask;
         endcase
      end

      // pins carry the selected clock before inversion
      n.tclk_pin = tx_sel;
      n.rclk_pin = rx_sel;
      n.tclk_oe = (s.tmode.clock_output_mode == CKO_CONT) ||
                  (s.tmode.clock_output_mode == CKO_XFER && busy);
      n.rclk_oe = (s.rmode.clock_output_mode == CKO_CONT) ||
                  (s.rmode.clock_output_mode == CKO_XFER && s.rxen);
      n.rsec_clk = rx_sel ^ s.rmode.clock_invert;

      // level interrupt; flags clear themselves as data moves
      n.irq = |(status[IRQ_W-1:0] & s.imask);
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // ----------------------------------------
   // outputs, all from flops
   // ----------------------------------------
   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign irq = s.irq;
   assign tx_serial_clock_pin_out = s.tclk_pin;
   assign tx_serial_clock_pin_oe = s.tclk_oe;
   assign rx_serial_clock_pin_out = s.rclk_pin;
   assign rx_serial_clock_pin_oe = s.rclk_oe;
   assign tx_serial_out = s.tx_out;
   assign rx_section_clock = s.rsec_clk;

endmodule

// file: sim/codec_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// external codec: clock source and sink
// ----------------------------------------
module codec_model (
   input wire logic pclk,
   input wire logic run,
   input wire logic clr,
   input wire logic sclk,
   input wire logic sclk_oe,
   input wire logic sdata,
   output logic ext_clk,
   output logic fsync,
   output logic [7:0] word,
   output logic [5:0] nbits
);
   logic [1:0] cnt;
   initial cnt = 2'h0;
   initial ext_clk = 1'b0;
   assign fsync = 1'b0;
   // pclk/8 clock, still outside frames
   always @(posedge pclk) begin
      cnt <= run ? cnt + 2'h1 : 2'h0;
      if (!run)
         ext_clk <= 1'b0;
      else if (cnt == 2'h3)
         ext_clk <= ~ext_clk;
   end
   // sample data on rising clock while driven
   always @(posedge sclk or posedge clr) begin
      if (clr) begin
         word <= 8'h00;
         nbits <= 6'h00;
      end else if (sclk_oe) begin
         word <= {word[6:0], sdata};
         nbits <= nbits + 6'h01;
      end
   end
endmodule

// file: sim/sync_serial_sva.sv
`timescale 1ns/1ps
module sync_serial_checker import sync_serial_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic tx_serial_clock_pin_out,
   input wire logic tx_serial_clock_pin_oe,
   input wire logic rx_serial_clock_pin_out,
   input wire logic rx_serial_clock_pin_oe,
   input wire logic rx_section_clock
);
   // ----------------------------------------
   // shadow of clock setup
   // ----------------------------------------
   logic [11:0] div_q;
   logic [5:0] rm;
   logic [5:0] tm;
   logic [15:0] age;
   logic [11:0] run;
   logic rprev;
   logic wr;
   logic steady;
   logic rdc;
   logic tdc;
   assign wr = psel & penable & pready & pwrite;
   // age gate keeps checks off while divider resettles
   assign steady = age > ({4'h0, div_q} << 1) + 16'd6;
   assign rdc = rm[1:0] == CKS_DIV && rm[4:2] == CKO_CONT;
   assign tdc = tm[1:0] == CKS_DIV && tm[4:2] == CKO_CONT;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= '0;
         rm <= '0;
         tm <= '0;
         age <= '0;
         run <= '0;
         rprev <= 1'b0;
      end else begin
         rprev <= rx_serial_clock_pin_out;
         run <= (rx_serial_clock_pin_out != rprev) ? 12'h1 : run + 12'h1;
         age <= wr ? 16'h0 : (age == 16'hFFFF ? age : age + 16'h1);
         if (wr && paddr == CLOCK_PRESCALE_REG_OFS)
            div_q <= pwdata[11:0];
         if (wr && paddr == RECEIVE_CLOCK_MODE_REG_OFS)
            rm <= pwdata[5:0];
         if (wr && paddr == TRANSMIT_CLOCK_MODE_REG_OFS)
            tm <= pwdata[5:0];
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   pready_slot_a: assert property (setup_s |=> pready)
      else $error("no ready after setup");
   ready_cause_a: assert property (pready |-> $past(psel && !penable))
      else $error("ready without setup");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error outside access");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   div_idle_a: assert property (
      div_q == '0 && age > 16'd8 && rdc |-> $stable(rx_serial_clock_pin_out))
      else $error("divider runs at zero");
   div_phase_a: assert property (
      steady && div_q != '0 && rdc && rx_serial_clock_pin_out != rprev
      |-> run == div_q) else $error("divided phase length wrong");
   shared_div_a: assert property (
      steady && rdc && tdc |-> tx_serial_clock_pin_out ==
      rx_serial_clock_pin_out) else $error("pin clocks differ");
   rx_invert_a: assert property (
      steady && rdc |-> rx_section_clock == (rx_serial_clock_pin_out ^ rm[5]))
      else $error("receive inversion wrong");
   oe_cont_a: assert property (
      age > 16'd2 && rm[4:2] == CKO_CONT |-> rx_serial_clock_pin_oe)
      else $error("receive pin not driven");
   oe_none_a: assert property (
      age > 16'd2 && tm[4:2] == CKO_NONE |-> !tx_serial_clock_pin_oe)
      else $error("transmit pin driven");
endmodule

bind sync_serial_controller sync_serial_checker i_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr),
   .tx_serial_clock_pin_out(tx_serial_clock_pin_out),
   .tx_serial_clock_pin_oe(tx_serial_clock_pin_oe),
   .rx_serial_clock_pin_out(rx_serial_clock_pin_out),
   .rx_serial_clock_pin_oe(rx_serial_clock_pin_oe),
   .rx_section_clock(rx_section_clock));

// file: sim/sync_serial_controller_tb.sv
`timescale 1ns/1ps
module sync_serial_controller_tb import sync_serial_pkg::*;;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic run = 1'b0;
   logic clr = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, irq, tk_o, tk_oe, rk_o, rk_oe, td, rsc;
   logic ext, fs, tk, rk;
   logic [7:0] word;
   logic [5:0] nbits;
   int n_errors = 0;
   int num_checks = 0;
   // pin level: device when enabled, else codec clock
   assign tk = tk_oe ? tk_o : ext;
   assign rk = rk_oe ? rk_o : ext;
   sync_serial_controller i_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .tx_serial_clock_pin_in(tk), .tx_serial_clock_pin_out(tk_o),
      .tx_serial_clock_pin_oe(tk_oe), .rx_serial_clock_pin_in(rk),
      .rx_serial_clock_pin_out(rk_o), .rx_serial_clock_pin_oe(rk_oe),
      .tx_frame_sync_pin(fs), .tx_serial_out(td), .rx_section_clock(rsc));
   codec_model i_codec (.pclk(pclk), .run(run), .clr(clr), .sclk(tk),
      .sclk_oe(tk_oe), .sdata(td), .ext_clk(ext), .fsync(fs), .word(word),
      .nbits(nbits));
   initial begin
      forever #2.5 pclk = ~pclk;
   end
   // ----------------------------------------
   // bus and compare tasks
   // ----------------------------------------
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string m);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t %s", $time, m);
      end
   endtask
   // cycles until the receive pin clock changes, capped at 50
   task automatic hold_len(output int k);
      logic v;
      v = rk_o;
      k = 0;
      while (rk_o === v && k < 50) begin
         @(posedge pclk);
         k++;
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs();
      logic [31:0] q;
      logic e;
      apb(1'b0, STATUS_REG_OFS, 32'h0, q, e);
      chk(q[1], 1'b1, "empty after reset");
      apb(1'b0, 8'hFC, 32'h0, q, e);
      chk(q, 32'h0, "unmapped read data");
      chk(e, 1'b1, "unmapped read error");
      wr(IRQ_ENABLE_REG_OFS, 32'h2);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b1, "irq on empty");
      wr(IRQ_DISABLE_REG_OFS, 32'h2);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0, "irq masked");
      $display("test regs done");
   endtask
   task automatic t_div();
      int k;
      wr(CLOCK_PRESCALE_REG_OFS, 32'h3);
      wr(RECEIVE_CLOCK_MODE_REG_OFS, 32'h26);
      wr(TRANSMIT_CLOCK_MODE_REG_OFS, 32'h06);
      repeat (10) @(posedge pclk);
      hold_len(k);
      hold_len(k);
      chk(k, 3, "half period");
      chk({tk_oe, rk_oe}, 2'b11, "pins driven");
      chk(rsc, !rk_o, "inverted section clock");
      wr(CLOCK_PRESCALE_REG_OFS, 32'h0);
      repeat (8) @(posedge pclk);
      hold_len(k);
      chk(k, 50, "divider idle");
      $display("test div done");
   endtask
   task automatic t_tx();
      int k;
      logic [31:0] q;
      logic e;
      wr(CLOCK_PRESCALE_REG_OFS, 32'h1);
      wr(TRANSMIT_FRAME_MODE_REG_OFS, 32'h87);
      wr(TRANSMIT_CLOCK_MODE_REG_OFS, 32'h0A);
      wr(CONTROL_REG_OFS, 32'h100);
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      wr(TRANSMIT_HOLDING_REG_OFS, 32'hA5);
      for (k = 0; k < 200 && nbits != 6'd8; k++)
         @(posedge pclk);
      chk(word, 8'hA5, "word msb first");
      repeat (10) @(posedge pclk);
      apb(1'b0, STATUS_REG_OFS, 32'h0, q, e);
      chk(q[1], 1'b1, "empty after shift");
      chk(nbits, 6'd8, "bit count");
      chk({tk_oe, td}, 2'b00, "idle pin and data");
      $display("test tx done");
   endtask
   task automatic t_ext();
      logic [31:0] q;
      logic e;
      wr(TRANSMIT_CLOCK_MODE_REG_OFS, 32'h00);
      wr(TRANSMIT_HOLDING_REG_OFS, 32'h3C);
      repeat (30) @(posedge pclk);
      apb(1'b0, STATUS_REG_OFS, 32'h0, q, e);
      chk(q[1:0], 2'b00, "held without clock");
      run <= 1'b1;
      repeat (200) @(posedge pclk);
      apb(1'b0, STATUS_REG_OFS, 32'h0, q, e);
      chk(q[1:0], 2'b11, "sent on pin clock");
      run <= 1'b0;
      $display("test ext done");
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      close_out();
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_div();
      t_tx();
      t_ext();
      close_out();
   end
endmodule
